// ==== hdl/gblc_regs.vh ====
// Register map, field positions and reset values of the gauge/boost/LED
// control bank. Included by the register bank and the testbench; definitions only.
`ifndef GBLC_REGS_VH
`define GBLC_REGS_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define GBLC_IDX_GAUGE_CTRL      8'h24
`define GBLC_IDX_CHARGE_CLEAR    8'h25
`define GBLC_IDX_SINK_ENABLES    8'h26
`define GBLC_IDX_BOOST_CFG       8'h27
`define GBLC_IDX_GROUP_ASSIGN    8'h2D
`define GBLC_IDX_OUTPUT_STATUS   8'h2E

// ==========================================================================
// Decoded register selects
`define GBLC_SEL_NONE            3'h0
`define GBLC_SEL_GAUGE_CTRL      3'h1
`define GBLC_SEL_CHARGE_CLEAR    3'h2
`define GBLC_SEL_SINK_ENABLES    3'h3
`define GBLC_SEL_BOOST_CFG       3'h4
`define GBLC_SEL_GROUP_ASSIGN    3'h5
`define GBLC_SEL_OUTPUT_STATUS   3'h6

// ==========================================================================
// Gauge control fields
`define GBLC_GAUGE_EN_BIT        0
`define GBLC_SLEEP_MODE_BIT      1
`define GBLC_SLEEP_TIME_BIT      2
`define GBLC_GAUGE_MASK          8'h07
`define GBLC_GAUGE_RESET         8'h00

// Charge-state clear field (write-only)
`define GBLC_CLEAR_BIT           7

// Boost and sink enable fields
`define GBLC_BL_ON_BIT           0
`define GBLC_SINK_LSB            1
`define GBLC_SINK_MSB            4
`define GBLC_BOOST_ON_BIT        5
`define GBLC_ENABLES_MASK        8'h3F
`define GBLC_ENABLES_RESET       8'h00

// Boost configuration fields
`define GBLC_IPK_BIT             0
`define GBLC_OVP_LSB             2
`define GBLC_OVP_MSB             3
`define GBLC_FADE_BIT            5
`define GBLC_BIAS_BIT            6
`define GBLC_STANDALONE_BIT      7
`define GBLC_BOOST_MASK          8'hED
`define GBLC_BOOST_RESET         8'h00

// Group assignment: bits 3..0 place channels 5..2 in the grouped backlight
`define GBLC_ASSIGN_MASK         8'h0F
`define GBLC_ASSIGN_RESET        8'h00

// ==========================================================================
// AXI response codes
`define GBLC_RESP_OKAY           2'h0
`define GBLC_RESP_SLVERR         2'h2

`endif

// ==== hdl/gblc_sink_gate.v ====
// Per-channel gating of the individual current sink enables.
// Assumes enables and assignments come from registers on the same clock.
`timescale 1ns/10ps

module gblc_sink_gate #(
	parameter CHANNELS = 4
) (
	// Clock and reset
	input  wire                clk,
	input  wire                rst_b,
	// Software settings
	input  wire [CHANNELS-1:0] individualOn,
	input  wire [CHANNELS-1:0] groupAssign,
	// Effective sink enables
	output wire [CHANNELS-1:0] sinkOn
);

	// ======================================================================
	// Gating, one flop per channel
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gChan
			reg sinkOn_r;
			// A grouped channel follows the backlight, so its own enable is ignored
			always @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					sinkOn_r <= 1'b0;
				end else begin
					sinkOn_r <= individualOn[ch] & ~groupAssign[ch];
				end
			end
			assign sinkOn[ch] = sinkOn_r;
		end
	endgenerate

endmodule

// ==== hdl/gblc_reg_bank.v ====
// Control register bank for the fuel gauge, boost regulator and LED sinks,
// reached over AXI4-Lite with one 32-bit word per 8-bit register.
// Assumes a single clock domain; outputs feed analogue control logic.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`include "gblc_regs.vh"

// Overview of operation
// - Gauge control bit 2 picks sleep update interval: 0 five, 1 twenty minutes.
// - Gauge control bit 1 enables gauge sleep mode; read/write, resets zero.
// - Gauge control bit 0 enables the fuel gauge; resets zero.
// - Writing 1 to clear bit 7 resets charge-state and voltage readings.
// - Enable bit 5 turns boost output on, only in standalone mode.
// - Enable bits 4..1 turn on sinks 5..2, ignored when channel grouped.
// - Enable bit 0 turns grouped backlight on; resets zero.
// - Boost config bit 7 selects standalone (1) or LED mode (0).
// - Boost config bit 6 picks bias target, only in LED mode.
// - Boost config bit 5 enables fade-in/fade-out override; resets zero.
// - Boost config bits 3:2 select overvoltage threshold; reset 00.
// - Boost config bit 0 selects peak current limit; 0 is 600 mA.
// - Per-channel assignment bit puts channels 2..5 in grouped backlight.
module gblc_reg_bank #(
	parameter ADDR_W = 12
) (
	// Clock and reset
	input  wire              clk,
	input  wire              rst_b,
	// AXI4-Lite write address channel
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire [2:0]        s_axi_awprot,
	// AXI4-Lite write data channel
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	// AXI4-Lite write response channel
	output wire              s_axi_bvalid,
	input  wire              s_axi_bready,
	output wire [1:0]        s_axi_bresp,
	// AXI4-Lite read address channel
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire [2:0]        s_axi_arprot,
	// AXI4-Lite read data channel
	output wire              s_axi_rvalid,
	input  wire              s_axi_rready,
	output wire [31:0]       s_axi_rdata,
	output wire [1:0]        s_axi_rresp,
	// Fuel gauge controls
	output wire              gaugeEnable,
	output wire              gaugeSleepMode,
	output wire              sleepLongInterval,
	output wire              readingsClear,
	// Boost regulator controls
	output wire              boostStandalone,
	output wire              boostOutputOn,
	output wire              biasBacklightOnly,
	output wire              fadeOverride,
	output wire [1:0]        overvoltageThreshold,
	output wire              peakCurrentLow,
	// LED sink controls
	output wire              groupedBacklightOn,
	output wire [3:0]        sinkGroupAssign,
	output wire [3:0]        sinkIndividualOn
);

	// ======================================================================
	// Address decode, shared by the write and read paths
	function [2:0] decodeSel;
		input [ADDR_W-1:0] addr;
		begin
			decodeSel = `GBLC_SEL_NONE;
			if (addr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}}) begin
				case (addr[9:2])
					`GBLC_IDX_GAUGE_CTRL:    decodeSel = `GBLC_SEL_GAUGE_CTRL;
					`GBLC_IDX_CHARGE_CLEAR:  decodeSel = `GBLC_SEL_CHARGE_CLEAR;
					`GBLC_IDX_SINK_ENABLES:  decodeSel = `GBLC_SEL_SINK_ENABLES;
					`GBLC_IDX_BOOST_CFG:     decodeSel = `GBLC_SEL_BOOST_CFG;
					`GBLC_IDX_GROUP_ASSIGN:  decodeSel = `GBLC_SEL_GROUP_ASSIGN;
					`GBLC_IDX_OUTPUT_STATUS: decodeSel = `GBLC_SEL_OUTPUT_STATUS;
					default:                 decodeSel = `GBLC_SEL_NONE;
				endcase
			end
		end
	endfunction

	// ======================================================================
	// Storage
	reg  [7:0]        gaugeCtrl_r;
	reg  [7:0]        sinkEnables_r;
	reg  [7:0]        boostCfg_r;
	reg  [7:0]        groupAssign_r;
	reg               readingsClear_r;

	// Write channel holding registers
	reg               awHeld_r;
	reg  [ADDR_W-1:0] awAddr_r;
	reg               wHeld_r;
	reg  [7:0]        wData_r;
	reg               wLane0_r;
	reg               bValid_r;
	reg  [1:0]        bResp_r;

	// Read channel registers
	reg               rValid_r;
	reg  [31:0]       rData_r;
	reg  [1:0]        rResp_r;

	// Registered effective controls
	reg               boostOutputOn_r;
	reg               biasBacklightOnly_r;

	wire [2:0]        wrSel;
	wire [2:0]        rdSel;
	wire              wrFire;
	wire              wrLive;
	wire              rdFire;
	wire [3:0]        sinkOn;
	reg  [7:0]        rdByte;

	// ======================================================================
	// Write address and data are caught independently, in either order
	assign s_axi_awready = ~awHeld_r & ~bValid_r;
	assign s_axi_wready  = ~wHeld_r & ~bValid_r;
	assign wrFire        = awHeld_r & wHeld_r & ~bValid_r;
	assign wrSel         = decodeSel(awAddr_r);
	// Only byte lane 0 carries register data
	assign wrLive        = wrFire & wLane0_r;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			awHeld_r <= 1'b0;
			awAddr_r <= {ADDR_W{1'b0}};
			wHeld_r  <= 1'b0;
			wData_r  <= 8'h00;
			wLane0_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end else if (wrFire) begin
				awHeld_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r  <= 1'b1;
				wData_r  <= s_axi_wdata[7:0];
				wLane0_r <= s_axi_wstrb[0];
			end else if (wrFire) begin
				wHeld_r <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR and store nothing
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bValid_r <= 1'b0;
			bResp_r  <= `GBLC_RESP_OKAY;
		end else begin
			if (wrFire) begin
				bValid_r <= 1'b1;
				bResp_r  <= (wrSel == `GBLC_SEL_NONE) ? `GBLC_RESP_SLVERR : `GBLC_RESP_OKAY;
			end else if (s_axi_bready) begin
				bValid_r <= 1'b0;
			end
		end
	end

	// Response outputs straight from their flops
	// A new write waits until this answer is taken, so one write at a time
	assign s_axi_bvalid = bValid_r;
	assign s_axi_bresp  = bResp_r;

	// ======================================================================
	// Register updates; masks drop unused bits so they read back zero
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gaugeCtrl_r   <= `GBLC_GAUGE_RESET;
			sinkEnables_r <= `GBLC_ENABLES_RESET;
			boostCfg_r    <= `GBLC_BOOST_RESET;
			groupAssign_r <= `GBLC_ASSIGN_RESET;
		end else if (wrLive) begin
			case (wrSel)
				`GBLC_SEL_GAUGE_CTRL: begin
					gaugeCtrl_r <= wData_r & `GBLC_GAUGE_MASK;
				end
				`GBLC_SEL_SINK_ENABLES: begin
					sinkEnables_r <= wData_r & `GBLC_ENABLES_MASK;
				end
				`GBLC_SEL_BOOST_CFG: begin
					boostCfg_r <= wData_r & `GBLC_BOOST_MASK;
				end
				`GBLC_SEL_GROUP_ASSIGN: begin
					groupAssign_r <= wData_r & `GBLC_ASSIGN_MASK;
				end
				default: begin
					gaugeCtrl_r <= gaugeCtrl_r;
				end
			endcase
		end
	end

	// Clear strobe: one cycle, only for a write that carries a 1
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			readingsClear_r <= 1'b0;
		end else begin
			readingsClear_r <= wrLive && (wrSel == `GBLC_SEL_CHARGE_CLEAR) &&
				wData_r[`GBLC_CLEAR_BIT];
		end
	end

	// ======================================================================
	// Mode-dependent boost controls
	// Registered so the outputs never glitch while a mode change settles
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			boostOutputOn_r     <= 1'b0;
			biasBacklightOnly_r <= 1'b0;
		end else begin
			boostOutputOn_r     <= boostCfg_r[`GBLC_STANDALONE_BIT] &
				sinkEnables_r[`GBLC_BOOST_ON_BIT];
			biasBacklightOnly_r <= ~boostCfg_r[`GBLC_STANDALONE_BIT] &
				boostCfg_r[`GBLC_BIAS_BIT];
		end
	end

	// Individual sinks, gated by the group assignment
	gblc_sink_gate #(
		.CHANNELS     (4)
	) uSinkGate (
		.clk          (clk),
		.rst_b        (rst_b),
		.individualOn (sinkEnables_r[`GBLC_SINK_MSB:`GBLC_SINK_LSB]),
		.groupAssign  (groupAssign_r[3:0]),
		.sinkOn       (sinkOn)
	);

	// ======================================================================
	// Read path: one outstanding read, answered the cycle after acceptance
	assign s_axi_arready = ~rValid_r;
	assign rdFire        = s_axi_arvalid & ~rValid_r;
	assign rdSel         = decodeSel(s_axi_araddr);

	// Read data mux; the clear register always reads zero
	always @* begin
		rdByte = 8'h00;
		case (rdSel)
			`GBLC_SEL_GAUGE_CTRL:    rdByte = gaugeCtrl_r;
			`GBLC_SEL_CHARGE_CLEAR:  rdByte = 8'h00;
			`GBLC_SEL_SINK_ENABLES:  rdByte = sinkEnables_r;
			`GBLC_SEL_BOOST_CFG:     rdByte = boostCfg_r;
			`GBLC_SEL_GROUP_ASSIGN:  rdByte = groupAssign_r;
			`GBLC_SEL_OUTPUT_STATUS: rdByte = {2'h0, biasBacklightOnly_r, boostOutputOn_r,
				sinkOn};
			default:                 rdByte = 8'h00;
		endcase
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rValid_r <= 1'b0;
			rData_r  <= 32'h00000000;
			rResp_r  <= `GBLC_RESP_OKAY;
		end else begin
			if (rdFire) begin
				rValid_r <= 1'b1;
				rData_r  <= {24'h000000, rdByte};
				rResp_r  <= (rdSel == `GBLC_SEL_NONE) ? `GBLC_RESP_SLVERR : `GBLC_RESP_OKAY;
			end else if (s_axi_rready) begin
				rValid_r <= 1'b0;
			end
		end
	end

	// Read answer outputs straight from their flops
	// Upper bytes are always zero; each register is only eight bits wide
	assign s_axi_rvalid = rValid_r;
	assign s_axi_rdata  = rData_r;
	assign s_axi_rresp  = rResp_r;

	// ======================================================================
	// Control outputs
	// Plain settings come straight from storage; only gated ones lag an edge
	// Users must allow that lag before relying on the gated controls
	assign gaugeEnable          = gaugeCtrl_r[`GBLC_GAUGE_EN_BIT];
	assign gaugeSleepMode       = gaugeCtrl_r[`GBLC_SLEEP_MODE_BIT];
	assign sleepLongInterval    = gaugeCtrl_r[`GBLC_SLEEP_TIME_BIT];
	assign readingsClear        = readingsClear_r;
	assign boostStandalone      = boostCfg_r[`GBLC_STANDALONE_BIT];
	assign boostOutputOn        = boostOutputOn_r;
	assign biasBacklightOnly    = biasBacklightOnly_r;
	assign fadeOverride         = boostCfg_r[`GBLC_FADE_BIT];
	assign overvoltageThreshold = boostCfg_r[`GBLC_OVP_MSB:`GBLC_OVP_LSB];
	assign peakCurrentLow       = boostCfg_r[`GBLC_IPK_BIT];
	assign groupedBacklightOn   = sinkEnables_r[`GBLC_BL_ON_BIT];
	assign sinkGroupAssign      = groupAssign_r[3:0];
	assign sinkIndividualOn     = sinkOn;

endmodule

// ==== verification/gblc_reg_bank_monitor.sv ====
// Concurrent checks on the ports of the gauge/boost/LED control bank.
// Assumes one clock domain, clk, with rst_b as its asynchronous active-low reset.
`timescale 1ns/10ps

// ==========================================================================
// Checker
module gblc_reg_bank_monitor (
	// Clock and reset
	input wire        clk,
	input wire        rst_b,
	// Bus handshakes
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// Controls
	input wire        readingsClear,
	input wire        boostStandalone,
	input wire        boostOutputOn,
	input wire        biasBacklightOnly,
	input wire [3:0]  sinkGroupAssign,
	input wire [3:0]  sinkIndividualOn
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Answers hold until the master takes them
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write not answered");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write request taken while busy");
	a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read request taken while busy");
	// Gating of effective controls, one edge behind the settings
	a_boost_gated: assert property (boostOutputOn |-> $past(boostStandalone))
		else $error("boost on outside standalone mode");
	a_sink_gated: assert property ((sinkIndividualOn & $past(sinkGroupAssign)) == 4'h0)
		else $error("grouped channel driven as individual sink");
	a_bias_ledmode: assert property (biasBacklightOnly |-> !$past(boostStandalone))
		else $error("bias target applied in standalone mode");
	// Clear is a single pulse, only around a write response
	a_clear_pulse: assert property (readingsClear |-> (s_axi_bvalid || $past(s_axi_bvalid)) ##1 !readingsClear)
		else $error("clear pulse malformed");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");

	// Main scenarios reached
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_clear: cover property (readingsClear);
	c_boost: cover property (boostOutputOn);
	c_sinks: cover property (sinkIndividualOn == 4'hA);
endmodule

bind gblc_reg_bank gblc_reg_bank_monitor uMon (.*);

// ==== verification/gblc_testbench.sv ====
// Self-checking bench for the gauge/boost/LED control bank over AXI4-Lite.
// Assumes the bank answers with OKAY on mapped and SLVERR on unmapped words.
`timescale 1ns/10ps
`include "gblc_regs.vh"

module testbench;
	// ======================================================================
	// Stimulus and observed signals
	logic clk = 0, rst_b = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, overvoltageThreshold;
	logic [31:0] s_axi_rdata;
	logic gaugeEnable, gaugeSleepMode, sleepLongInterval, readingsClear;
	logic boostStandalone, boostOutputOn, biasBacklightOnly, fadeOverride;
	logic peakCurrentLow, groupedBacklightOn;
	logic [3:0] sinkGroupAssign, sinkIndividualOn;
	int nFail = 0, testsRun = 0, cycles = 0, clearCount = 0;

	gblc_reg_bank DUT (.*);

	// Clock, pulse counter and watchdog
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (readingsClear === 1'b1) clearCount++;
		if (cycles == 5000) begin
			nFail++;
			reportAndStop();
		end
	end

	// ======================================================================
	// Shared tasks
	task automatic check(input [31:0] seen, input [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			nFail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic settle();
		@(posedge clk);
		#1;
	endtask

	// Address and data offered together, each released when taken
	task automatic wr(input [7:0] idx, input [7:0] d, input [1:0] expResp);
		logic done;
		done = 0;
		@(posedge clk);
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!done) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin
				done = 1;
				check(s_axi_bresp, expResp);
				s_axi_bready <= 0;
			end
		end
	endtask

	task automatic rd(input [7:0] idx, input [31:0] exp, input [1:0] expResp);
		logic done;
		done = 0;
		@(posedge clk);
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		while (!done) begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin
				done = 1;
				check(s_axi_rdata, exp);
				check(s_axi_rresp, expResp);
				s_axi_rready <= 0;
			end
		end
	endtask

	// ======================================================================
	// Scenarios
	task automatic testResetValues();
		rd(`GBLC_IDX_GAUGE_CTRL, 0, 2'h0);
		rd(`GBLC_IDX_SINK_ENABLES, 0, 2'h0);
		rd(`GBLC_IDX_BOOST_CFG, 0, 2'h0);
		rd(`GBLC_IDX_GROUP_ASSIGN, 0, 2'h0);
		rd(`GBLC_IDX_OUTPUT_STATUS, 0, 2'h0);
		check({gaugeEnable, gaugeSleepMode, groupedBacklightOn, fadeOverride}, 0);
	endtask

	task automatic testGauge();
		wr(`GBLC_IDX_GAUGE_CTRL, 8'hFF, 2'h0);
		rd(`GBLC_IDX_GAUGE_CTRL, 32'h07, 2'h0);
		check({sleepLongInterval, gaugeSleepMode, gaugeEnable}, 3'h7);
		wr(`GBLC_IDX_GAUGE_CTRL, 8'h05, 2'h0);
		settle();
		check({sleepLongInterval, gaugeSleepMode, gaugeEnable}, 3'h5);
		wr(`GBLC_IDX_GAUGE_CTRL, 8'h02, 2'h0);
		settle();
		check({sleepLongInterval, gaugeSleepMode, gaugeEnable}, 3'h2);
		// A write without byte lane 0 must leave the register alone
		s_axi_wstrb <= 4'hE;
		wr(`GBLC_IDX_GAUGE_CTRL, 8'h01, 2'h0);
		s_axi_wstrb <= 4'hF;
		settle();
		check({sleepLongInterval, gaugeSleepMode, gaugeEnable}, 3'h2);
	endtask

	// Only a written 1 in bit 7 may fire the clear
	task automatic testClear();
		int c0;
		c0 = clearCount;
		wr(`GBLC_IDX_CHARGE_CLEAR, 8'h7F, 2'h0);
		repeat (2) settle();
		check(clearCount - c0, 0);
		wr(`GBLC_IDX_CHARGE_CLEAR, 8'h80, 2'h0);
		repeat (2) settle();
		check(clearCount - c0, 1);
		rd(`GBLC_IDX_CHARGE_CLEAR, 0, 2'h0);
	endtask

	task automatic testSinks();
		wr(`GBLC_IDX_SINK_ENABLES, 8'hFF, 2'h0);
		settle();
		check({boostOutputOn, groupedBacklightOn, sinkIndividualOn}, 6'h1F);
		wr(`GBLC_IDX_GROUP_ASSIGN, 8'h05, 2'h0);
		settle();
		check({sinkGroupAssign, sinkIndividualOn}, 8'h5A);
		wr(`GBLC_IDX_BOOST_CFG, 8'h80, 2'h0);
		settle();
		check(boostOutputOn, 1);
		rd(`GBLC_IDX_OUTPUT_STATUS, 32'h1A, 2'h0);
		rd(`GBLC_IDX_SINK_ENABLES, 32'h3F, 2'h0);
		wr(`GBLC_IDX_SINK_ENABLES, 8'h00, 2'h0);
		settle();
		check({boostOutputOn, groupedBacklightOn, sinkIndividualOn}, 6'h00);
	endtask

	// Every threshold code, with unused bits 4 and 1 written high
	task automatic testBoostCfg();
		for (int i = 0; i < 4; i++) begin
			wr(`GBLC_IDX_BOOST_CFG, {3'b011, 1'b1, i[1:0], 1'b1, i[0]}, 2'h0);
			rd(`GBLC_IDX_BOOST_CFG, {3'b011, 1'b0, i[1:0], 1'b0, i[0]}, 2'h0);
			check({overvoltageThreshold, peakCurrentLow}, {i[1:0], i[0]});
			check({boostStandalone, biasBacklightOnly, fadeOverride}, 3'h3);
		end
		wr(`GBLC_IDX_BOOST_CFG, 8'hC0, 2'h0);
		settle();
		check({boostStandalone, biasBacklightOnly, fadeOverride}, 3'h4);
	endtask

	// Reset in mid-run must bring the gauge, boost and group settings back to zero
	task automatic testMidReset();
		wr(`GBLC_IDX_GAUGE_CTRL, 8'h07, 2'h0);
		@(posedge clk);
		rst_b <= 0;
		repeat (2) @(posedge clk);
		rst_b <= 1;
		rd(`GBLC_IDX_GAUGE_CTRL, 0, 2'h0);
		rd(`GBLC_IDX_BOOST_CFG, 0, 2'h0);
		rd(`GBLC_IDX_GROUP_ASSIGN, 0, 2'h0);
		check({boostStandalone, fadeOverride, groupedBacklightOn, readingsClear}, 0);
	endtask

	task automatic testUnmapped();
		rd(8'h30, 0, 2'h2);
		wr(8'h30, 8'hFF, 2'h2);
	endtask

	// ======================================================================
	// Verdict, the single end of the run
	task automatic reportAndStop();
		if (nFail == 0 && testsRun > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1;
		testResetValues();
		testGauge();
		testClear();
		testSinks();
		testBoostCfg();
		testMidReset();
		testUnmapped();
		reportAndStop();
	end
endmodule
